//--- rtl/usart_core_pkg.sv
// Package with register map, field positions, reset values and counts
// Assumes a single clock domain and a plain address/strobe register port
package usart_core_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_ONE_OFS = 8'h00; // Control register one
   localparam logic [7:0] CTRL_THREE_OFS = 8'h04; // Control register three
   localparam logic [7:0] STATUS_OFS = 8'h08; // Status register
   localparam logic [7:0] BAUD_OFS = 8'h0C; // Oversample divisor
   localparam logic [7:0] RX_DATA_OFS = 8'h10; // Receive data register
   localparam logic [7:0] TX_DATA_OFS = 8'h14; // Transmit data register
   localparam logic [7:0] RTO_DUR_OFS = 8'h18; // Receive time-out duration
   // Control register one fields
   localparam int TX_EN_POS = 0;
   localparam int RX_EN_POS = 1;
   localparam int PAR_EN_POS = 2;
   localparam int PAR_ODD_POS = 3;
   localparam int TWO_STOP_POS = 4;
   localparam int DBL_SPEED_POS = 5;
   localparam int SYNC_MODE_POS = 6;
   localparam int CPOL_POS = 7;
   localparam int TXE_IE_POS = 8;
   localparam int TXD_IE_POS = 9;
   localparam int RXD_IE_POS = 10;
   localparam int CHAR_LSB_POS = 12; // Three bits: 0..4 give 5..9 data bits
   // Control register three fields
   localparam int RTO_EN_POS = 0;
   localparam int RTO_IE_POS = 1;
   // Status register fields
   localparam int ST_TXE_POS = 0;
   localparam int ST_TXD_POS = 1;
   localparam int ST_RXD_POS = 2;
   localparam int ST_FE_POS = 3;
   localparam int ST_OVR_POS = 4;
   localparam int ST_PE_POS = 5;
   localparam int ST_RTO_POS = 6;
   // Reset values
   localparam logic [15:0] CTRL_ONE_RST = 16'h3000; // Eight data bits
   localparam logic [1:0] CTRL_THREE_RST = 2'h0;
   localparam logic [15:0] BAUD_RST = 16'h0000;
   localparam logic [7:0] RTO_DUR_RST = 8'hFF;
   // Oversampling ratios and centre sample numbers
   localparam logic [4:0] OS_NORMAL = 5'h10;
   localparam logic [4:0] OS_DOUBLE = 5'h08;
   localparam logic [4:0] CENTRE_NORMAL = 5'h08;
   localparam logic [4:0] CENTRE_DOUBLE = 5'h04;
   localparam logic [3:0] MIN_DATA_BITS = 4'h5;
   localparam logic [3:0] MAX_DATA_BITS = 4'h9;
endpackage

//--- rtl/usart_core.sv
// USART transmit and receive core with register port and serial pins
// Assumes pins are asynchronous to sys_clk_i; serial clock comes from the partner
// What this block does
// - Transmitter loads frames only while transmit enable set
// - Queued character loads shifter when idle or after stop
// - Empty flag set while transmit buffer empty
// - Empty interrupt while flag and enable set
// - Done flag sets after frame with nothing queued, write one clears
// - Done interrupt while flag and enable set
// - Parity bit inserted after data when enabled
// - Transmit disable waits for current frame end
// - Receive disable stops, flushes buffer, clears flag
// - Receive flag set while buffer holds data
// - Receive interrupt while flag and enable set
// - Bits sampled after start through first stop
// - First stop completes frame, moves to buffer if empty or read that cycle
// - Frame error shows low sampled first stop
// - Overrun when buffer full, cleared by read
// - Parity error flag, zero when parity disabled
// - Receiver checks parity over received data bits
// - Oversample sixteen normal, eight double speed
// - Start validated on centre samples, resynchronise each
// - Data bits decided by centre sample vote
// - Stop needs two of three high samples
// - Time-out counts baud periods from start bit
// - Time-out length is duration plus one
// - Parity is XOR, inverted for odd
// - Low start bit, LSB first, idle high
// - Clock polarity zero: change rise, sample fall
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
module usart_core #(
   parameter int DIV_W = 16 // Width of the oversample divisor
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire logic serial_in_pin_i,
   input wire logic serial_clock_pin_i,
   output logic serial_out_pin_o,
   output logic serial_out_oe_n_o,
   output logic tx_buffer_empty_irq_o,
   output logic tx_done_irq_o,
   output logic rx_done_irq_o,
   output logic rx_timeout_irq_o
);
   // Software state
   logic [15:0] ctrl_one_q; // Control register one
   logic [1:0] ctrl_three_q; // Control register three
   logic [DIV_W-1:0] baud_q; // Oversample divisor
   logic [7:0] rto_dur_q; // Time-out duration
   logic [31:0] rdata_q; // Registered read data
   // Pin synchronisers, stable levels
   logic [2:0] rx_sync_q;
   logic [2:0] sck_sync_q;
   logic rx_lvl_q;
   logic sck_lvl_q;
   // Transmit path
   logic [8:0] tx_buf_q;
   logic tx_full_q;
   logic [11:0] tx_shift_q;
   logic [3:0] tx_left_q;
   logic tx_busy_q;
   logic tx_out_q;
   logic [3:0] tx_os_q;
   logic tx_done_q;
   // Receive path
   logic rx_busy_q;
   logic [3:0] rx_idx_q;
   logic [3:0] rx_os_q;
   logic [1:0] vote_q;
   logic [8:0] rx_shift_q;
   logic rx_par_q;
   logic [8:0] rx_buf_q;
   logic rx_full_q;
   logic fe_q;
   logic pe_q;
   logic ovr_q;
   // Time-out and oversample divider
   logic [DIV_W-1:0] div_q;
   logic [3:0] rto_os_q;
   logic [8:0] rto_cnt_q;
   logic rto_armed_q;
   logic rto_flag_q;
   logic rto_en_prev_q;

   // Field decode
   wire tx_en = ctrl_one_q[usart_core_pkg::TX_EN_POS];
   wire rx_en = ctrl_one_q[usart_core_pkg::RX_EN_POS];
   wire par_en = ctrl_one_q[usart_core_pkg::PAR_EN_POS];
   wire par_odd = ctrl_one_q[usart_core_pkg::PAR_ODD_POS];
   wire two_stop = ctrl_one_q[usart_core_pkg::TWO_STOP_POS];
   wire dbl = ctrl_one_q[usart_core_pkg::DBL_SPEED_POS];
   wire sync_mode = ctrl_one_q[usart_core_pkg::SYNC_MODE_POS];
   wire cpol = ctrl_one_q[usart_core_pkg::CPOL_POS];
   wire [2:0] char_sel = ctrl_one_q[usart_core_pkg::CHAR_LSB_POS +: 3];
   wire rto_en = ctrl_three_q[usart_core_pkg::RTO_EN_POS];
   // Data bit count, codes above 4 read as nine
   wire [3:0] nbits = (char_sel > 3'h4) ? usart_core_pkg::MAX_DATA_BITS
                                        : usart_core_pkg::MIN_DATA_BITS + {1'b0, char_sel};
   // Oversample ratio and centre sample number
   wire [4:0] os_ratio = dbl ? usart_core_pkg::OS_DOUBLE : usart_core_pkg::OS_NORMAL;
   wire [4:0] centre = dbl ? usart_core_pkg::CENTRE_DOUBLE : usart_core_pkg::CENTRE_NORMAL;
   wire [3:0] os_last = 4'(os_ratio - 5'h01);
   // Bus decode
   wire wr_ctrl1 = reg_wr_i && (reg_addr_i == usart_core_pkg::CTRL_ONE_OFS);
   wire wr_ctrl3 = reg_wr_i && (reg_addr_i == usart_core_pkg::CTRL_THREE_OFS);
   wire wr_stat = reg_wr_i && (reg_addr_i == usart_core_pkg::STATUS_OFS);
   wire wr_baud = reg_wr_i && (reg_addr_i == usart_core_pkg::BAUD_OFS);
   wire wr_txd = reg_wr_i && (reg_addr_i == usart_core_pkg::TX_DATA_OFS);
   wire wr_rto = reg_wr_i && (reg_addr_i == usart_core_pkg::RTO_DUR_OFS);
   wire rd_rxd = reg_rd_i && (reg_addr_i == usart_core_pkg::RX_DATA_OFS);
   wire clr_done = wr_stat && reg_wdata_i[usart_core_pkg::ST_TXD_POS];
   wire clr_rto = wr_stat && reg_wdata_i[usart_core_pkg::ST_RTO_POS];
   // Status word as software sees it
   wire [6:0] status = {rto_flag_q, pe_q & par_en, ovr_q, fe_q, rx_full_q, tx_done_q, !tx_full_q};
   wire [31:0] rd_mux =
      (reg_addr_i == usart_core_pkg::CTRL_ONE_OFS) ? {16'h0000, ctrl_one_q} :
      (reg_addr_i == usart_core_pkg::CTRL_THREE_OFS) ? {30'h00000000, ctrl_three_q} :
      (reg_addr_i == usart_core_pkg::STATUS_OFS) ? {25'h0000000, status} :
      (reg_addr_i == usart_core_pkg::BAUD_OFS) ? 32'(baud_q) :
      (reg_addr_i == usart_core_pkg::RX_DATA_OFS) ? {23'h000000, rx_buf_q} :
      (reg_addr_i == usart_core_pkg::TX_DATA_OFS) ? {23'h000000, tx_buf_q} :
      (reg_addr_i == usart_core_pkg::RTO_DUR_OFS) ? {24'h000000, rto_dur_q} :
      32'h00000000; // Unmapped reads zero
   // Pin edge detection; first stage read only by second
   wire rx_agree = (rx_sync_q[1] == rx_sync_q[2]);
   wire sck_agree = (sck_sync_q[1] == sck_sync_q[2]);
   wire rx_fall = rx_agree && !rx_sync_q[2] && rx_lvl_q;
   wire sck_rise = sck_agree && sck_sync_q[2] && !sck_lvl_q;
   wire sck_fall = sck_agree && !sck_sync_q[2] && sck_lvl_q;
   wire sck_change = cpol ? sck_fall : sck_rise;
   wire sck_sample = cpol ? sck_rise : sck_fall;
   // Oversample tick from the divisor
   wire os_tick = (div_q == baud_q);
   // Parity over the low n data bits
   function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n, input logic odd);
      logic p;
      p = odd;
      for (int i = 0; i < 9; i++) begin
         if (4'(i) < n) begin
            p = p ^ d[i];
         end
      end
      return p;
   endfunction
   // Bits after the start bit: data LSB first, parity, then stop ones
   function automatic logic [11:0] frame_of(input logic [8:0] d, input logic [3:0] n,
                                           input logic pe, input logic odd);
      logic [11:0] f;
      f = 12'hFFF;
      for (int i = 0; i < 9; i++) begin
         if (4'(i) < n) begin
            f[i] = d[i];
         end
      end
      if (pe) begin
         f[n] = parity_of(d, n, odd);
      end
      return f;
   endfunction
   // Transmit timing
   wire tx_bit_tick = sync_mode ? sck_change : (os_tick && (tx_os_q == os_last));
   wire tx_last = tx_busy_q && tx_bit_tick && (tx_left_q == 4'h1);
   wire tx_load = tx_en && tx_full_q && (!tx_busy_q || tx_last);
   wire [3:0] tx_total = 4'(4'h2 + nbits + {3'h0, par_en} + {3'h0, two_stop});
   wire tx_set_done = tx_last && !tx_load;
   // Receive decision: vote in async mode, sampling edge in sync mode
   wire [3:0] rx_os_pos = 4'(centre) + 4'h1; // Third centre sample, zero based
   wire async_dec = !sync_mode && rx_busy_q && os_tick && (rx_os_q == rx_os_pos);
   wire maj = (vote_q[0] & vote_q[1]) | (vote_q[0] & rx_lvl_q) | (vote_q[1] & rx_lvl_q);
   wire dec_ev = rx_en && (sync_mode ? sck_sample : async_dec);
   wire dec_val = sync_mode ? rx_lvl_q : maj;
   wire [3:0] stop_idx = 4'(nbits + {3'h0, par_en} + 4'h1);
   wire start_ok = dec_ev && (rx_idx_q == 4'h0) && !dec_val;
   wire frame_end = dec_ev && rx_busy_q && (rx_idx_q == stop_idx);
   wire [8:0] rx_data = rx_shift_q >> (4'h9 - nbits);
   wire par_bad = par_en && (parity_of(rx_data, nbits, par_odd) != rx_par_q);
   wire rx_store = frame_end && (!rx_full_q || rd_rxd);
   // Time-out baud tick
   wire rto_tick = os_tick && (rto_os_q == os_last);
   wire rto_expire = rto_armed_q && rto_tick && (rto_cnt_q == {1'b0, rto_dur_q});
   // Registered data and line outputs, combinational output enable and interrupt lines
   assign reg_rdata_o = rdata_q;
   assign serial_out_pin_o = tx_out_q;
   assign serial_out_oe_n_o = !(tx_en || tx_busy_q);
   assign tx_buffer_empty_irq_o = !tx_full_q && ctrl_one_q[usart_core_pkg::TXE_IE_POS];
   assign tx_done_irq_o = tx_done_q && ctrl_one_q[usart_core_pkg::TXD_IE_POS];
   assign rx_done_irq_o = rx_full_q && ctrl_one_q[usart_core_pkg::RXD_IE_POS];
   assign rx_timeout_irq_o = rto_flag_q && ctrl_three_q[usart_core_pkg::RTO_IE_POS];

   // Software registers and read data
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         ctrl_one_q <= usart_core_pkg::CTRL_ONE_RST;
         ctrl_three_q <= usart_core_pkg::CTRL_THREE_RST;
         baud_q <= DIV_W'(usart_core_pkg::BAUD_RST);
         rto_dur_q <= usart_core_pkg::RTO_DUR_RST;
         rdata_q <= 32'h00000000;
      end else begin
         if (wr_ctrl1) ctrl_one_q <= reg_wdata_i[15:0];
         if (wr_ctrl3) ctrl_three_q <= reg_wdata_i[1:0];
         if (wr_baud) baud_q <= reg_wdata_i[DIV_W-1:0];
         if (wr_rto) rto_dur_q <= reg_wdata_i[7:0];
         rdata_q <= reg_rd_i ? rd_mux : 32'h00000000;
      end
   end
   // Three-stage pin synchronisers; level moves once stages two and three agree
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         rx_sync_q <= 3'h7;
         sck_sync_q <= 3'h0;
         rx_lvl_q <= 1'b1;
         sck_lvl_q <= 1'b0;
      end else begin
         rx_sync_q <= {rx_sync_q[1:0], serial_in_pin_i};
         sck_sync_q <= {sck_sync_q[1:0], serial_clock_pin_i};
         if (rx_agree) rx_lvl_q <= rx_sync_q[2];
         if (sck_agree) sck_lvl_q <= sck_sync_q[2];
      end
   end
   // Free-running oversample divider
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         div_q <= '0;
      end else begin
         div_q <= os_tick ? '0 : div_q + 1'b1;
      end
   end
   // Transmit buffer; a write while full is dropped to keep the queued character
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         tx_buf_q <= 9'h000;
         tx_full_q <= 1'b0;
      end else if (wr_txd && !tx_full_q) begin
         tx_buf_q <= reg_wdata_i[8:0];
         tx_full_q <= 1'b1;
      end else if (tx_load) begin
         tx_full_q <= 1'b0;
      end
   end
   // Transmit shifter; sub-count restarts at load so the start bit is full length
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         tx_shift_q <= 12'hFFF;
         tx_left_q <= 4'h0;
         tx_busy_q <= 1'b0;
         tx_out_q <= 1'b1;
         tx_os_q <= 4'h0;
      end else if (tx_load) begin
         tx_shift_q <= frame_of(tx_buf_q, nbits, par_en, par_odd);
         tx_left_q <= tx_total;
         tx_busy_q <= 1'b1;
         tx_out_q <= 1'b0;
         tx_os_q <= 4'h0;
      end else if (tx_last) begin
         tx_busy_q <= 1'b0;
         tx_out_q <= 1'b1; // Idle line high
      end else if (tx_busy_q) begin
         if (os_tick) tx_os_q <= (tx_os_q == os_last) ? 4'h0 : tx_os_q + 4'h1;
         if (tx_bit_tick) begin
            tx_out_q <= tx_shift_q[0];
            tx_shift_q <= {1'b1, tx_shift_q[11:1]};
            tx_left_q <= tx_left_q - 4'h1;
         end
      end
   end
   // Transmit done flag; setting beats a clear in the same cycle
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         tx_done_q <= 1'b0;
      end else if (tx_set_done) begin
         tx_done_q <= 1'b1;
      end else if (clr_done) begin
         tx_done_q <= 1'b0;
      end
   end
   // Receive sequencer: hunt, start check, data, parity, first stop
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i || !rx_en) begin
         rx_busy_q <= 1'b0;
         rx_idx_q <= 4'h0;
         rx_os_q <= 4'h0;
         vote_q <= 2'h3;
         rx_shift_q <= 9'h000;
         rx_par_q <= 1'b0;
      end else if (!sync_mode && !rx_busy_q && rx_fall) begin
         rx_busy_q <= 1'b1; // Resynchronise on a falling edge while hunting
         rx_os_q <= 4'h0;
         rx_idx_q <= 4'h0;
      end else begin
         if (!sync_mode && rx_busy_q && os_tick) begin
            rx_os_q <= (rx_os_q == os_last) ? 4'h0 : rx_os_q + 4'h1;
            vote_q <= {vote_q[0], rx_lvl_q}; // Centre samples collect here
         end
         if (dec_ev && (rx_busy_q || sync_mode)) begin
            if (rx_idx_q == 4'h0) begin
               rx_busy_q <= start_ok; // False start returns to hunting
               rx_idx_q <= start_ok ? 4'h1 : 4'h0;
            end else if (rx_idx_q == stop_idx) begin
               rx_busy_q <= 1'b0;
               rx_idx_q <= 4'h0; // Second stop bit never looked at
            end else begin
               if (rx_idx_q <= nbits) rx_shift_q <= {dec_val, rx_shift_q[8:1]};
               else rx_par_q <= dec_val;
               rx_idx_q <= rx_idx_q + 4'h1;
            end
         end
      end
   end
   // Receive buffer and error flags; a read in the same cycle frees room
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i || !rx_en) begin
         rx_buf_q <= 9'h000;
         rx_full_q <= 1'b0;
         fe_q <= 1'b0;
         pe_q <= 1'b0;
         ovr_q <= 1'b0;
      end else if (rx_store) begin
         rx_buf_q <= rx_data;
         rx_full_q <= 1'b1;
         fe_q <= !dec_val;
         pe_q <= par_bad;
         ovr_q <= 1'b0;
      end else if (frame_end) begin
         ovr_q <= 1'b1;
      end else if (rd_rxd) begin
         rx_full_q <= 1'b0;
         ovr_q <= 1'b0;
      end
   end
   // Receive time-out counter
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         rto_os_q <= 4'h0;
         rto_cnt_q <= 9'h000;
         rto_armed_q <= 1'b0;
         rto_flag_q <= 1'b0;
         rto_en_prev_q <= 1'b0;
      end else begin
         rto_en_prev_q <= rto_en;
         if (os_tick) rto_os_q <= (rto_os_q == os_last) ? 4'h0 : rto_os_q + 4'h1;
         if (!rto_en) begin
            rto_armed_q <= 1'b0;
         end else if (start_ok || !rto_en_prev_q) begin
            rto_armed_q <= 1'b1;
            rto_cnt_q <= 9'h000;
            rto_os_q <= 4'h0;
         end else if (rto_expire) begin
            rto_armed_q <= 1'b0;
         end else if (rto_armed_q && rto_tick) begin
            rto_cnt_q <= rto_cnt_q + 9'h001;
         end
         if (rto_expire) rto_flag_q <= 1'b1;
         else if (clr_rto) rto_flag_q <= 1'b0;
      end
   end
   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   a_write_fills_buf: assert property ((wr_txd && !tx_full_q && !tx_en) |=> (!status[0] ##1 !status[0]))
      else $error("empty flag stayed set after a queued write");
   a_load_start_low: assert property (tx_load |=> (!serial_out_pin_o && tx_busy_q))
      else $error("frame did not open with a low start bit");
   a_idle_line_high: assert property (!tx_busy_q |-> serial_out_pin_o)
      else $error("line not high while transmitter idle");
   a_no_load_off: assert property ((!tx_en && !tx_busy_q) |=> !tx_busy_q)
      else $error("transmitter started while disabled");
   a_disable_waits: assert property ((tx_busy_q && !tx_en && !tx_last) |=> tx_busy_q)
      else $error("frame cut short by disable");
   a_done_clear: assert property ((clr_done && !tx_set_done) |=> !tx_done_q)
      else $error("done flag not cleared by write of one");
   a_done_set: assert property (tx_set_done |=> (tx_done_q && !tx_busy_q))
      else $error("done flag missing after frame");
   a_rx_flush: assert property (!rx_en |=> (!rx_done_irq_o && !status[2]))
      else $error("receive flag survived disable");
   a_overrun_set: assert property ((frame_end && rx_full_q && !rd_rxd) |=> (ovr_q && rx_full_q))
      else $error("overrun not flagged");
   a_parity_off: assert property ((rx_store && !par_en) |=> !pe_q)
      else $error("parity error shown with parity off");
   a_stop_error: assert property (rx_store |=> (fe_q == !$past(dec_val)))
      else $error("frame error does not follow stop sample");
   c_tx_frame: cover property (tx_set_done);
   c_back_to_back: cover property (tx_last && tx_load);
   c_rx_store: cover property (rx_store && !sync_mode);
   c_overrun: cover property (frame_end && rx_full_q);
   c_timeout: cover property (rto_expire);
endmodule

//--- test/usart_partner.sv
// Remote serial device: sends async or clocked frames, captures async frames
// Assumes 1 ns units, idle-high lines and a serial clock still between frames
`timescale 1ns/1ps
module usart_partner (
   input wire logic line_in_i, // Device transmit line
   output logic line_out_o, // Device receive line
   output logic sclk_o // Serial clock, low outside frames
);
   // Idle levels at time zero
   initial begin
      line_out_o = 1'b1;
      sclk_o = 1'b0;
   end
   // Async frame: low start, then n bits LSB first, then idle high
   task automatic send(input logic [11:0] b, input int n, input int bit_ns);
      line_out_o = 1'b0;
      #(bit_ns);
      for (int k = 0; k < n; k++) begin
         line_out_o = b[k];
         #(bit_ns);
      end
      line_out_o = 1'b1;
   endtask
   // Clocked frame, polarity zero: change at rise, device samples at fall
   task automatic send_sync(input logic [11:0] b, input int n);
      for (int k = 0; k <= n; k++) begin
         sclk_o = 1'b1;
         line_out_o = (k == 0) ? 1'b0 : b[k-1];
         #32;
         sclk_o = 1'b0;
         #32;
      end
      line_out_o = 1'b1;
   endtask
   // Capture n bits at mid-bit; the hunt for a start is bounded
   task automatic capture(output logic [11:0] w, input int n);
      int i;
      w = '0;
      for (i = 0; i < 4000 && line_in_i !== 1'b0; i++) #1;
      #32;
      for (int k = 0; k < n; k++) begin
         #64;
         w[k] = line_in_i;
      end
   endtask
endmodule

//--- test/usart_core_tb.sv
// Self-checking bench for the serial core at divisor 0 (64 ns bit)
// Assumes the partner model drives the receive line and serial clock
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
   $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module usart_core_tb;
   logic sys_clk_i, nrst_i, reg_wr_i, reg_rd_i; // Clock, reset, strobes
   logic [7:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, s; // Bus and last read
   logic rx_pin, sclk, tx_pin, oe_n, irq_e, irq_d, irq_r, irq_t;
   logic [11:0] w1, w2; // Captured frames
   int n_errors = 0;
   int total_checks = 0;
   usart_core u_usart_core (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .serial_in_pin_i(rx_pin), .serial_clock_pin_i(sclk), .serial_out_pin_o(tx_pin),
      .serial_out_oe_n_o(oe_n), .tx_buffer_empty_irq_o(irq_e), .tx_done_irq_o(irq_d),
      .rx_done_irq_o(irq_r), .rx_timeout_irq_o(irq_t));
   usart_partner u_usart_partner (.line_in_i(tx_pin), .line_out_o(rx_pin), .sclk_o(sclk));
   // 250 MHz clock
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
      #1; // Callers look only after the write has landed
   endtask
   // One-cycle read strobe; data stands only in the next cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Reset values and an unmapped address
   task automatic t_reset;
      rd(usart_core_pkg::STATUS_OFS, s);
      `CHK("status", 32'h00000001, s)
      rd(usart_core_pkg::CTRL_ONE_OFS, s);
      `CHK("ctrl1", 32'h00003000, s)
      rd(usart_core_pkg::RTO_DUR_OFS, s);
      `CHK("rto dur", 32'h000000FF, s)
      rd(8'h1C, s);
      `CHK("unmapped", 32'h00000000, s)
      `CHK("idle tx", 3'b110, {tx_pin, oe_n, irq_e})
   endtask
   // Two back-to-back characters with two stop bits, flags and interrupts
   task automatic t_tx;
      wr(usart_core_pkg::CTRL_ONE_OFS, 32'h00003311);
      `CHK("empty irq", 1'b1, irq_e)
      fork
         begin
            u_usart_partner.capture(w1, 10);
            u_usart_partner.capture(w2, 10);
         end
         begin
            wr(usart_core_pkg::TX_DATA_OFS, 32'h000000A5);
            wr(usart_core_pkg::TX_DATA_OFS, 32'h0000003C);
            rd(usart_core_pkg::STATUS_OFS, s);
            `CHK("busy status", 2'b00, s[1:0])
            `CHK("full irq", 1'b0, irq_e)
         end
      join
      `CHK("frame1", 12'h3A5, w1)
      `CHK("frame2", 12'h33C, w2)
      repeat (40) @(posedge sys_clk_i);
      rd(usart_core_pkg::STATUS_OFS, s);
      `CHK("done status", 32'h00000003, s)
      `CHK("done irq", 1'b1, irq_d)
      wr(usart_core_pkg::STATUS_OFS, 32'h00000002);
      rd(usart_core_pkg::STATUS_OFS, s);
      `CHK("done clear", 32'h00000001, s)
   endtask
   // Nine-bit character, even parity: held while disabled, then disabled mid-frame
   task automatic t_par;
      wr(usart_core_pkg::CTRL_ONE_OFS, 32'h00004004);
      wr(usart_core_pkg::TX_DATA_OFS, 32'h00000107);
      rd(usart_core_pkg::STATUS_OFS, s);
      `CHK("held", 3'b011, {s[0], tx_pin, oe_n})
      fork
         u_usart_partner.capture(w1, 11);
         begin
            wr(usart_core_pkg::CTRL_ONE_OFS, 32'h00004005);
            wr(usart_core_pkg::CTRL_ONE_OFS, 32'h00004004);
            `CHK("oe mid", 1'b0, oe_n)
         end
      join
      `CHK("par frame", 12'h507, w1)
      repeat (20) @(posedge sys_clk_i);
      `CHK("released", 2'b11, {oe_n, tx_pin})
      wr(usart_core_pkg::STATUS_OFS, 32'h00000002);
   endtask
   // Reception normal and double speed
   task automatic t_rx;
      wr(usart_core_pkg::CTRL_ONE_OFS, 32'h00003402);
      u_usart_partner.send(12'h15A, 9, 64);
      repeat (20) @(posedge sys_clk_i);
      `CHK("rx irq", 1'b1, irq_r)
      rd(usart_core_pkg::STATUS_OFS, s);
      `CHK("rx status", 32'h00000005, s)
      rd(usart_core_pkg::RX_DATA_OFS, s);
      `CHK("rx data", 32'h0000005A, s)
      `CHK("rx empty irq", 1'b0, irq_r)
      wr(usart_core_pkg::CTRL_ONE_OFS, 32'h00003422);
      u_usart_partner.send(12'h1C3, 9, 32);
      repeat (20) @(posedge sys_clk_i);
      rd(usart_core_pkg::RX_DATA_OFS, s);
      `CHK("dbl data", 32'h000000C3, s)
   endtask
   // Odd parity: bad parity with low stop, then a clean frame
   task automatic t_err;
      wr(usart_core_pkg::CTRL_ONE_OFS, 32'h0000340E);
      u_usart_partner.send(12'h101, 10, 64);
      repeat (20) @(posedge sys_clk_i);
      rd(usart_core_pkg::STATUS_OFS, s);
      `CHK("fe pe set", 2'b11, {s[5], s[3]})
      rd(usart_core_pkg::RX_DATA_OFS, s);
      `CHK("err data", 32'h00000001, s)
      u_usart_partner.send(12'h303, 10, 64);
      repeat (20) @(posedge sys_clk_i);
      rd(usart_core_pkg::STATUS_OFS, s);
      `CHK("fe pe clear", 2'b00, {s[5], s[3]})
      rd(usart_core_pkg::RX_DATA_OFS, s);
      `CHK("ok data", 32'h00000003, s)
   endtask
   // Overrun, then disable flush
   task automatic t_ovr;
      wr(usart_core_pkg::CTRL_ONE_OFS, 32'h00003402);
      u_usart_partner.send(12'h111, 9, 64);
      u_usart_partner.send(12'h122, 9, 64);
      repeat (20) @(posedge sys_clk_i);
      rd(usart_core_pkg::STATUS_OFS, s);
      `CHK("overrun", 2'b11, {s[4], s[2]})
      rd(usart_core_pkg::RX_DATA_OFS, s);
      `CHK("kept data", 32'h00000011, s)
      rd(usart_core_pkg::STATUS_OFS, s);
      `CHK("ovr clear", 1'b0, s[4])
      u_usart_partner.send(12'h133, 9, 64);
      repeat (20) @(posedge sys_clk_i);
      wr(usart_core_pkg::CTRL_ONE_OFS, 32'h00003400);
      rd(usart_core_pkg::RX_DATA_OFS, s);
      `CHK("flushed", 32'h00000000, s)
      `CHK("flush irq", 1'b0, irq_r)
   endtask
   // Time-out of duration 2 is three baud periods (48 clocks)
   task automatic t_rto;
      int i;
      wr(usart_core_pkg::RTO_DUR_OFS, 32'h00000002);
      wr(usart_core_pkg::CTRL_THREE_OFS, 32'h00000003);
      repeat (36) @(posedge sys_clk_i);
      `CHK("rto early", 1'b0, irq_t)
      for (i = 0; i < 16 && irq_t !== 1'b1; i++) @(posedge sys_clk_i);
      `CHK("rto irq", 1'b1, irq_t)
      wr(usart_core_pkg::STATUS_OFS, 32'h00000040);
      `CHK("rto clear", 1'b0, irq_t)
   endtask
   // Clocked slave reception, polarity zero
   task automatic t_sync;
      wr(usart_core_pkg::CTRL_ONE_OFS, 32'h00003042);
      u_usart_partner.send_sync(12'h196, 9);
      repeat (20) @(posedge sys_clk_i);
      rd(usart_core_pkg::RX_DATA_OFS, s);
      `CHK("sync data", 32'h00000096, s)
   endtask
   // Hang guard
   initial begin
      #200000;
      n_errors++;
      summarize();
   end
   // Main sequence
   initial begin
      nrst_i = 1'b0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 32'h00000000;
      repeat (4) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      t_reset();
      t_tx();
      t_par();
      t_rx();
      t_err();
      t_ovr();
      t_rto();
      t_sync();
      summarize();
   end
endmodule
